/* File: include/tce_pkg.sv */
// Purpose: constants, field layout and filter table of the timer channel
//          event control block
// Assumes: 16-bit register port, one register per word offset
// Notes:   shared by the design and its testbench
package tce_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IDEN = 8'h0C;
  localparam logic [7:0] OFS_ISTS = 8'h10;
  localparam logic [7:0] OFS_SWEVT = 8'h14;
  localparam logic [7:0] OFS_CM1 = 8'h18;
  localparam logic [7:0] OFS_CCTRL = 8'h20;
  localparam logic [7:0] OFS_CH1_COMPARE_CAPTURE_VALUE = 8'h34;
  localparam logic [7:0] OFS_C2DT = 8'h38;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_OVF = 0;
  localparam int BIT_CH1 = 1;
  localparam int BIT_TRG = 6;
  localparam int BIT_DMA_OVF = 8;
  localparam int BIT_DMA_CH1 = 9;
  localparam int BIT_RF_CH1 = 9;
  localparam int CTRL_OVF_DIS = 1;
  localparam int CTRL_OVF_SRC = 2;
  localparam int CTRL_DIR = 4;
  localparam int CTRL_CLKDIV = 8;
  localparam int CM_STRIDE = 8;
  localparam int CM_CFG = 0;
  localparam int CM_FAST = 2;
  localparam int CM_BUF = 3;
  localparam int CM_MODE = 4;
  localparam int CM_CLR = 7;
  localparam int CM_DIV = 2;
  localparam int CM_FLT = 4;
  localparam int CC_STRIDE = 4;
  localparam int CC_ON = 0;
  localparam int CC_POL = 1;

  // ****************************************
  // reset values and writable masks
  // ****************************************
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [15:0] CTRL_MASK = 16'h0316;
  localparam logic [15:0] IDEN_MASK = 16'h5F5F;
  localparam logic [15:0] ISTS_MASK = 16'h1E5F;
  localparam logic [15:0] CCTRL_MASK = 16'h0033;

  typedef enum logic [2:0] {
    OM_OFF = 3'h0, OM_SET = 3'h1, OM_CLR = 3'h2, OM_TGL = 3'h3,
    OM_LOW = 3'h4, OM_HIGH = 3'h5, OM_PWMA = 3'h6, OM_PWMB = 3'h7
  } tce_omode_t;

  typedef enum logic [1:0] {
    CFG_OUT = 2'h0, CFG_OWN = 2'h1, CFG_OTHER = 2'h2, CFG_ITRG = 2'h3
  } tce_cfg_t;

  // sampling period as a power of two of ref_clk cycles
  function automatic logic [2:0] tce_flt_shift(input logic [3:0] code,
                                               input logic [1:0] cdiv);
    logic [2:0] d;
    d = (cdiv == 2'h3) ? 3'h0 : {1'b0, cdiv};
    case (code)
      4'h1, 4'h2, 4'h3: tce_flt_shift = 3'h0;
      4'h4, 4'h5: tce_flt_shift = d + 3'h1;
      4'h6, 4'h7: tce_flt_shift = d + 3'h2;
      4'h8, 4'h9: tce_flt_shift = d + 3'h3;
      4'hA, 4'hB, 4'hC: tce_flt_shift = d + 3'h4;
      4'hD, 4'hE, 4'hF: tce_flt_shift = d + 3'h5;
      default: tce_flt_shift = d;
    endcase
  endfunction : tce_flt_shift

  // agreeing samples needed before an edge passes
  function automatic logic [3:0] tce_flt_n(input logic [3:0] code);
    case (code)
      4'h1: tce_flt_n = 4'h2;
      4'h2: tce_flt_n = 4'h4;
      4'h3, 4'h5, 4'h7, 4'h9, 4'hC, 4'hF: tce_flt_n = 4'h8;
      4'h4, 4'h6, 4'h8, 4'hB, 4'hE: tce_flt_n = 4'h6;
      4'hA, 4'hD: tce_flt_n = 4'h5;
      default: tce_flt_n = 4'h1;
    endcase
  endfunction : tce_flt_n

endpackage : tce_pkg

/* File: rtl/tce_top.sv */
// Purpose: event flags, dma and interrupt gating, software events and
//          channel 1/2 compare, capture, filter and divider
// Assumes: all inputs synchronous to ref_clk; counter core is outside
// Notes:   channels 3/4 report events through ch34_event only
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module tce_top #(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [tce_pkg::ADDR_W-1:0] addr,
  input wire logic [tce_pkg::DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [tce_pkg::DATA_W-1:0] rdata,
  input wire logic [CNT_W-1:0] cnt_val,
  input wire logic counter_overflow,
  input wire logic counter_reinit,
  input wire logic trigger_input,
  input wire logic suspend_mode,
  input wire logic trigger_input_select,
  input wire logic internal_trigger_channel_in,
  input wire logic external_input,
  input wire logic ch1_pin,
  input wire logic ch2_pin,
  input wire logic [1:0] ch34_event,
  input wire logic [1:0] ch34_is_input,
  output logic irq,
  output logic [4:0] dma_req,
  output logic ch1_raw_output,
  output logic ch2_raw_output,
  output logic overflow_event,
  output logic trigger_event
);
  import tce_pkg::*;

  // ****************************************
  // parameter check
  // ****************************************
  if (CNT_W < 16 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must lie between 16 and 32");
  end

  logic [15:0] ctrl_q, iden_q, ists_q, ists_d, cm_q, cc_q, rdata_q;
  logic [15:0] sw_ev, rd_mux, cm_new;
  logic [6:0] pre_q;
  logic trg_in_q, trig_evt, ovf_evt, irq_q, ovf_q, trg_q;
  logic [4:0] dma_q;
  logic [1:0] flt_q, cap_w, cmp_w, raw_q, in_mode;
  logic [3:0] evt_v, cap_v;
  logic [CNT_W-1:0] dt_q [2];
  logic [CNT_W-1:0] sh_q [2];
  logic [1:0] pins;

  assign pins = {ch2_pin, ch1_pin};

  // ****************************************
  // register writes
  // ****************************************
  assign sw_ev = (wr_en && addr == OFS_SWEVT) ? wdata : 16'h0000;

  always_comb begin
    cm_new = wdata;
    if (cc_q[CC_ON]) begin
      cm_new[1:0] = cm_q[1:0];
    end
    if (cc_q[CC_STRIDE + CC_ON]) begin
      cm_new[9:8] = cm_q[9:8];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl_q <= RST_REG;
      iden_q <= RST_REG;
      cm_q <= RST_REG;
      cc_q <= RST_REG;
    end else if (wr_en) begin
      if (addr == OFS_CTRL) begin
        ctrl_q <= wdata & CTRL_MASK;
      end
      if (addr == OFS_IDEN) begin
        iden_q <= wdata & IDEN_MASK;
      end
      if (addr == OFS_CM1) begin
        cm_q <= cm_new;
      end
      if (addr == OFS_CCTRL) begin
        cc_q <= wdata & CCTRL_MASK;
      end
    end
  end

  // ****************************************
  // trigger and overflow events
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      trg_in_q <= 1'b0;
    end else begin
      trg_in_q <= trigger_input;
    end
  end

  // suspend mode reacts to both edges
  assign trig_evt = (suspend_mode ? (trigger_input ^ trg_in_q)
                    : (trigger_input & ~trg_in_q))
                    | sw_ev[BIT_TRG];

  // disable bit blocks every source, counter overflow included
  assign ovf_evt = ~ctrl_q[CTRL_OVF_DIS] & (counter_overflow
                   | (~ctrl_q[CTRL_OVF_SRC]
                   & (sw_ev[BIT_OVF] | counter_reinit)));

  // free-running base for filter sampling ticks
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pre_q <= 7'h00;
    end else begin
      pre_q <= pre_q + 7'h01;
    end
  end

  // ****************************************
  // channels 1 and 2
  // ****************************************
  for (genvar c = 0; c < 2; c++) begin : g_ch
    localparam int B = c * CM_STRIDE;
    logic [1:0] cfg;
    logic [3:0] flt_code, fcnt_q, nreq;
    logic [2:0] mode, pcnt_q, lim;
    logic [6:0] mask;
    logic on, pol, tick, sel, sel_q, edge_w, act, match, match_q;
    logic pwm_a, raw_d;

    assign cfg = cm_q[B + CM_CFG +: 2];
    assign mode = cm_q[B + CM_MODE +: 3];
    assign flt_code = cm_q[B + CM_FLT +: 4];
    assign on = cc_q[c * CC_STRIDE + CC_ON];
    assign pol = cc_q[c * CC_STRIDE + CC_POL];
    assign in_mode[c] = (cfg != CFG_OUT);
    assign nreq = tce_flt_n(flt_code);
    assign mask = ~(7'h7F << tce_flt_shift(flt_code,
                  ctrl_q[CTRL_CLKDIV +: 2]));
    assign tick = ((pre_q & mask) == 7'h00);

    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        flt_q[c] <= 1'b0;
        fcnt_q <= 4'h0;
      end else if (tick) begin
        if (pins[c] == flt_q[c]) begin
          fcnt_q <= 4'h0;
        end else if (fcnt_q + 4'h1 >= nreq) begin
          flt_q[c] <= pins[c];
          fcnt_q <= 4'h0;
        end else begin
          fcnt_q <= fcnt_q + 4'h1;
        end
      end
    end

    always_comb begin
      case (cfg)
        CFG_OWN: sel = flt_q[c];
        CFG_OTHER: sel = flt_q[1 - c];
        CFG_ITRG: sel = trigger_input_select
                        & internal_trigger_channel_in;
        default: sel = 1'b0;
      endcase
    end

    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        sel_q <= 1'b0;
      end else begin
        sel_q <= sel;
      end
    end

    assign edge_w = pol ? (sel_q & ~sel) : (~sel_q & sel);
    assign act = on & in_mode[c] & edge_w;
    assign lim = 3'((4'h1 << cm_q[B + CM_DIV +: 2]) - 4'h1);

    always_ff @(posedge ref_clk) begin
      if (!reset_n || !on) begin
        pcnt_q <= 3'h0;
      end else if (act) begin
        pcnt_q <= (pcnt_q == lim) ? 3'h0 : pcnt_q + 3'h1;
      end
    end

    assign cap_w[c] = act && pcnt_q == lim;
    assign match = (cnt_val == dt_q[c]);
    assign cmp_w[c] = ~in_mode[c] & match & ~match_q;

    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        // starts high: a counter parked on the compare value is no event
        match_q <= 1'b1;
      end else begin
        match_q <= match;
      end
    end

    // compare/capture value and its shadow
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        dt_q[c] <= '0;
        sh_q[c] <= '0;
      end else if (cap_w[c]) begin
        dt_q[c] <= cnt_val;
      end else begin
        if (wr_en && addr == (c == 0 ? OFS_CH1_COMPARE_CAPTURE_VALUE : OFS_C2DT)) begin
          if (!in_mode[c] && cm_q[B + CM_BUF]) begin
            sh_q[c] <= CNT_W'(wdata);
          end else begin
            dt_q[c] <= CNT_W'(wdata);
          end
        end
        if (ovf_evt && !in_mode[c] && cm_q[B + CM_BUF]) begin
          dt_q[c] <= sh_q[c];
        end
      end
    end

    // pwm a: up counts high while dt above counter, down low while below
    assign pwm_a = ctrl_q[CTRL_DIR] ? (dt_q[c] >= cnt_val)
                   : (dt_q[c] > cnt_val);

    always_comb begin
      raw_d = raw_q[c];
      case (mode)
        OM_SET: raw_d = cmp_w[c] ? 1'b1 : raw_q[c];
        OM_CLR: raw_d = cmp_w[c] ? 1'b0 : raw_q[c];
        OM_TGL: raw_d = raw_q[c] ^ cmp_w[c];
        OM_LOW: raw_d = 1'b0;
        OM_HIGH: raw_d = 1'b1;
        OM_PWMA: raw_d = (cm_q[B + CM_FAST] && trig_evt) ? 1'b1
                         : pwm_a;
        OM_PWMB: raw_d = (cm_q[B + CM_FAST] && trig_evt) ? 1'b0
                         : ~pwm_a;
        default: raw_d = raw_q[c];
      endcase
      if (cm_q[B + CM_CLR] && external_input) begin
        raw_d = 1'b0;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        raw_q[c] <= 1'b0;
      end else if (!in_mode[c]) begin
        raw_q[c] <= raw_d;
      end
    end
  end

  // ****************************************
  // status flags, dma and interrupt
  // ****************************************
  assign evt_v = {ch34_event | sw_ev[4:3],
                  cap_w | cmp_w | sw_ev[2:1]};
  assign cap_v = {ch34_event & ch34_is_input, cap_w};

  always_comb begin
    ists_d = ists_q;
    if (wr_en && addr == OFS_ISTS) begin
      ists_d = ists_q & wdata;
    end
    if (rd_en && addr == OFS_CH1_COMPARE_CAPTURE_VALUE && in_mode[0]) begin
      ists_d[BIT_CH1] = 1'b0;
    end
    if (rd_en && addr == OFS_C2DT && in_mode[1]) begin
      ists_d[BIT_CH1 + 1] = 1'b0;
    end
    // sets come last so a clear in the same cycle loses
    ists_d = (ists_d | {3'h0, cap_v & ists_q[4:1], 2'h0, trig_evt,
              1'b0, evt_v, ovf_evt}) & ISTS_MASK;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ists_q <= RST_REG;
      dma_q <= 5'h00;
      irq_q <= 1'b0;
      ovf_q <= 1'b0;
      trg_q <= 1'b0;
    end else begin
      ists_q <= ists_d;
      dma_q <= {evt_v, ovf_evt} & iden_q[12:8];
      irq_q <= |({ists_q[BIT_TRG], ists_q[4:0]}
               & {iden_q[BIT_TRG], iden_q[4:0]});
      ovf_q <= ovf_evt;
      trg_q <= trig_evt;
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  always_comb begin
    case (addr)
      OFS_CTRL: rd_mux = ctrl_q;
      OFS_IDEN: rd_mux = iden_q;
      OFS_ISTS: rd_mux = ists_q;
      OFS_CM1: rd_mux = cm_q;
      OFS_CCTRL: rd_mux = cc_q;
      OFS_CH1_COMPARE_CAPTURE_VALUE: rd_mux = dt_q[0][15:0];
      OFS_C2DT: rd_mux = dt_q[1][15:0];
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rd_en ? rd_mux : 16'h0000;
    end
  end

  assign rdata = rdata_q;
  assign irq = irq_q;
  assign dma_req = dma_q;
  assign ch1_raw_output = raw_q[0];
  assign ch2_raw_output = raw_q[1];
  assign overflow_event = ovf_q;
  assign trigger_event = trg_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_dma_ovf;
    dma_q[0] |-> $past(ovf_evt) && $past(iden_q[BIT_DMA_OVF]);
  endproperty
  a_dma_ovf: assert property (p_dma_ovf)
    else $error("overflow dma without enabled event");

  property p_dma_ch1_off;
    !iden_q[BIT_DMA_CH1] |=> !dma_q[1];
  endproperty
  a_dma_ch1_off: assert property (p_dma_ch1_off)
    else $error("channel 1 dma while disabled");

  property p_irq;
    irq_q |-> $past(|({ists_q[BIT_TRG], ists_q[4:0]}
                    & {iden_q[BIT_TRG], iden_q[4:0]}));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without enabled flag");

  property p_recap;
    cap_w[0] && ists_q[BIT_CH1] |=> ists_q[BIT_RF_CH1];
  endproperty
  a_recap: assert property (p_recap)
    else $error("recapture not flagged");

  property p_trg;
    trig_evt |=> ists_q[BIT_TRG] ##0 trigger_event;
  endproperty
  a_trg: assert property (p_trg)
    else $error("trigger event not flagged");

  property p_cap;
    cap_w[0] |=> ists_q[BIT_CH1] && dt_q[0] == $past(cnt_val);
  endproperty
  a_cap: assert property (p_cap)
    else $error("capture did not store value and flag");

  property p_rd_clr;
    rd_en && addr == OFS_CH1_COMPARE_CAPTURE_VALUE && in_mode[0] && !evt_v[0]
      |=> !ists_q[BIT_CH1];
  endproperty
  a_rd_clr: assert property (p_rd_clr)
    else $error("data read did not clear channel 1 flag");

  property p_cmp;
    cmp_w[1] |=> ists_q[BIT_CH1 + 1];
  endproperty
  a_cmp: assert property (p_cmp)
    else $error("compare did not flag channel 2");

  property p_ovf;
    ovf_evt |=> ists_q[BIT_OVF] && overflow_event;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow not flagged");

  property p_sw_ovf;
    sw_ev[BIT_OVF] && !ctrl_q[CTRL_OVF_DIS] && !ctrl_q[CTRL_OVF_SRC]
      |-> ovf_evt;
  endproperty
  a_sw_ovf: assert property (p_sw_ovf)
    else $error("software overflow lost");

  property p_reinit;
    counter_reinit && ctrl_q[2:1] == 2'h0 |=> overflow_event;
  endproperty
  a_reinit: assert property (p_reinit)
    else $error("reinit did not give overflow");

  property p_sw_ch;
    sw_ev[BIT_CH1] |=> ists_q[BIT_CH1];
  endproperty
  a_sw_ch: assert property (p_sw_ch)
    else $error("software channel event lost");

  property p_cfg_lock;
    wr_en && addr == OFS_CM1 && cc_q[CC_ON] |=> $stable(cm_q[1:0]);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock)
    else $error("config changed while channel on");

  property p_force_low;
    cm_q[1:0] == 2'h0 && cm_q[6:4] == OM_LOW |=> !raw_q[0];
  endproperty
  a_force_low: assert property (p_force_low)
    else $error("forced low not low");

  property p_ext_clr;
    cm_q[1:0] == 2'h0 && cm_q[CM_CLR] && external_input |=> !raw_q[0];
  endproperty
  a_ext_clr: assert property (p_ext_clr)
    else $error("external input did not clear output");

  property p_buf;
    wr_en && addr == OFS_CH1_COMPARE_CAPTURE_VALUE && !in_mode[0] && cm_q[CM_BUF]
      && !ovf_evt |=> $stable(dt_q[0]);
  endproperty
  a_buf: assert property (p_buf)
    else $error("buffered write took effect at once");

  c_capture: cover property (cap_w[0] ##1 ists_q[BIT_CH1]);
  c_recap: cover property (ists_q[BIT_RF_CH1]);
  c_pwm: cover property (cm_q[6:4] == OM_PWMA ##1 raw_q[0] ##1 !raw_q[0]);
  c_dma: cover property (dma_q[0]);

endmodule : tce_top

/* File: dv/tce_far.sv */
// Purpose: far-side model of the counter core feeding the block
// Assumes: counter wraps at PER, overflow is a one-cycle pulse
// Notes:   run low freezes the count so tests can place values
`timescale 1ns/1ps
module tce_far #(
  parameter int PER = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic load,
  input wire logic [15:0] load_val,
  output logic [15:0] cnt_val,
  output logic counter_overflow
);
  // ****************************************
  // counter core
  // ****************************************
  always_ff @(posedge ref_clk) begin
    counter_overflow <= 1'b0;
    if (!reset_n) begin
      cnt_val <= 16'h0000;
    end else if (load) begin
      cnt_val <= load_val;
    end else if (run) begin
      cnt_val <= (cnt_val == 16'(PER - 1)) ? 16'h0000 : cnt_val + 16'h0001;
      counter_overflow <= (cnt_val == 16'(PER - 1));
    end
  end
endmodule : tce_far

/* File: dv/tb_timer_channel_event_control.sv */
// Purpose: self-checking bench for the timer channel event block
// Assumes: counter model tce_far; 16-bit counter
// Notes:   stimulus changes just after rising edges
`timescale 1ns/1ps
module tb_timer_channel_event_control;
  import tce_pkg::*;
  logic ref_clk, reset_n, wr_en, rd_en, run, load;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, cnt_val, load_val, d;
  logic counter_overflow, counter_reinit, trigger_input, suspend_mode;
  logic external_input, ch1_pin, ch2_pin, irq, ch1_raw_output;
  logic trigger_input_select, internal_trigger_channel_in;
  logic ch2_raw_output, overflow_event, trigger_event;
  logic [4:0] dma_req;
  logic [9:0] seen;
  int fails, total_checks;
  // output steps: cm1 low byte, direction, counter value
  logic [19:0] stp [14] = '{20'h50005, 20'h40005, 20'h10010, 20'h20010,
    20'h30010, 20'h30010, 20'h60005, 20'h60020, 20'h70005, 20'h70020,
    20'h60120, 20'h60110, 20'h70110, 20'hD0005};
  logic [13:0] exo = 14'b00101001010101;
  wire logic [9:0] mon = {irq, trigger_event, overflow_event,
    ch2_raw_output, ch1_raw_output, dma_req};

  tce_far #(.PER(8)) far (.ref_clk, .reset_n, .run, .load, .load_val,
    .cnt_val, .counter_overflow);
  tce_top #(.CNT_W(16)) dut (.ref_clk, .reset_n, .addr, .wdata, .wr_en,
    .rd_en, .rdata, .cnt_val, .counter_overflow, .counter_reinit,
    .trigger_input, .suspend_mode, .trigger_input_select,
    .internal_trigger_channel_in, .external_input, .ch1_pin,
    .ch2_pin, .ch34_event(2'b00), .ch34_is_input(2'b00), .irq, .dma_req,
    .ch1_raw_output, .ch2_raw_output, .overflow_event, .trigger_event);

  always #25 ref_clk = ~ref_clk;
  // pulses last one cycle, so they are gathered between edges
  always @(negedge ref_clk) seen = seen | mon;

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cb(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask : cb
  task automatic go(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : go
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [15:0] e,
                    input string nm);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
    chk(nm, e, d);
  endtask : rc
  task automatic setc(input logic [15:0] v);
    @(posedge ref_clk);
    load <= 1'b1;
    load_val <= v;
    @(posedge ref_clk);
    load <= 1'b0;
  endtask : setc
  task automatic ev(input logic [7:0] a, input logic [15:0] v);
    seen = '0;
    wr(a, v);
    go(4);
  endtask : ev
  task automatic p1(input logic v);
    ch1_pin <= v;
    go(6);
  endtask : p1
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    #5000000;
    fails++;
    give_verdict();
  end
  initial begin
    {ref_clk, reset_n, wr_en, rd_en, run, load, ch1_pin, ch2_pin} = '0;
    {counter_reinit, trigger_input, suspend_mode, external_input} = '0;
    {trigger_input_select, internal_trigger_channel_in} = '0;
    {addr, wdata, load_val, seen} = '0;
    fails = 0;
    total_checks = 0;
    go(6);
    reset_n <= 1'b1;
    cb("irq", 1'b0, irq);
    rc(OFS_IDEN, 16'h0000, "iden");
    rc(OFS_ISTS, 16'h0000, "ists");
    rc(OFS_CM1, 16'h0000, "cm1");
    rc(OFS_SWEVT, 16'h0000, "swevt");
    wr(8'h04, 16'hFFFF);
    rc(8'h04, 16'h0000, "unmapped");
    wr(OFS_IDEN, 16'hFFFF);
    rc(OFS_IDEN, 16'h5F5F, "iden");
    wr(OFS_IDEN, 16'h0000);
    $display("test registers done");

    ev(OFS_SWEVT, 16'h0001);
    cb("ovf", 1'b1, seen[7]);
    cb("dma0", 1'b0, seen[0]);
    cb("irq", 1'b0, seen[9]);
    rc(OFS_ISTS, 16'h0001, "ists");
    wr(OFS_IDEN, 16'h0303);
    ev(OFS_SWEVT, 16'h0003);
    cb("dma0", 1'b1, seen[0]);
    cb("dma1", 1'b1, seen[1]);
    cb("irq", 1'b1, seen[9]);
    rc(OFS_ISTS, 16'h0003, "ists");
    wr(OFS_ISTS, 16'h0000);
    go(3);
    cb("irq", 1'b0, irq);
    ev(OFS_SWEVT, 16'h0000);
    chk("zero", 16'h0000, {14'h0000, seen[8:7]});
    $display("test soft events done");

    wr(OFS_IDEN, 16'h0040);
    ev(OFS_SWEVT, 16'h0040);
    cb("trg", 1'b1, seen[8]);
    rc(OFS_ISTS, 16'h0040, "ists");
    cb("irq", 1'b1, irq);
    wr(OFS_ISTS, 16'h0000);
    seen = '0;
    trigger_input <= 1'b1;
    go(4);
    cb("trg", 1'b1, seen[8]);
    wr(OFS_ISTS, 16'h0000);
    suspend_mode <= 1'b1;
    go(2);
    trigger_input <= 1'b0;
    go(4);
    rc(OFS_ISTS, 16'h0040, "ists");
    suspend_mode <= 1'b0;
    wr(OFS_ISTS, 16'h0000);
    seen = '0;
    counter_reinit <= 1'b1;
    go(1);
    counter_reinit <= 1'b0;
    go(3);
    cb("reinit", 1'b1, seen[7]);
    wr(OFS_CTRL, 16'h0004);
    ev(OFS_SWEVT, 16'h0001);
    cb("ovfsrc", 1'b0, seen[7]);
    seen = '0;
    run <= 1'b1;
    go(20);
    run <= 1'b0;
    cb("cntovf", 1'b1, seen[7]);
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_ISTS, 16'h0000);
    $display("test trigger done");

    wr(OFS_CH1_COMPARE_CAPTURE_VALUE, 16'h0010);
    setc(16'h0005);
    external_input <= 1'b1;
    foreach (stp[i]) begin
      wr(OFS_CTRL, {11'h000, stp[i][8], 4'h0});
      wr(OFS_CM1, {8'h00, stp[i][19:12]});
      setc({8'h00, stp[i][7:0]});
      go(3);
      cb("raw1", exo[i], ch1_raw_output);
      setc(16'h0005);
    end
    rc(OFS_ISTS, 16'h0002, "ists");
    wr(OFS_CM1, 16'h0064);
    setc(16'h0020);
    go(3);
    ev(OFS_SWEVT, 16'h0040);
    cb("fast", 1'b1, seen[5]);
    wr(OFS_CM1, 16'h0068);
    setc(16'h0008);
    wr(OFS_CH1_COMPARE_CAPTURE_VALUE, 16'h0004);
    go(3);
    cb("buf", 1'b1, ch1_raw_output);
    ev(OFS_SWEVT, 16'h0001);
    cb("buf", 1'b0, ch1_raw_output);
    wr(OFS_CM1, 16'h5000);
    go(3);
    cb("raw2", 1'b1, ch2_raw_output);
    $display("test outputs done");

    wr(OFS_CM1, 16'h0001);
    wr(OFS_CCTRL, 16'h0001);
    wr(OFS_ISTS, 16'h0000);
    setc(16'h0033);
    p1(1'b1);
    rc(OFS_ISTS, 16'h0002, "ists");
    rc(OFS_CH1_COMPARE_CAPTURE_VALUE, 16'h0033, "ch1_compare_capture_value");
    rc(OFS_ISTS, 16'h0000, "ists");
    p1(1'b0);
    p1(1'b1);
    p1(1'b0);
    setc(16'h0055);
    p1(1'b1);
    rc(OFS_ISTS, 16'h0202, "ists");
    wr(OFS_ISTS, 16'h0000);
    rc(OFS_ISTS, 16'h0000, "ists");
    rc(OFS_CH1_COMPARE_CAPTURE_VALUE, 16'h0055, "ch1_compare_capture_value");
    p1(1'b0);
    wr(OFS_CCTRL, 16'h0000);
    wr(OFS_CM1, 16'h0005);
    wr(OFS_CCTRL, 16'h0001);
    wr(OFS_ISTS, 16'h0000);
    p1(1'b1);
    rc(OFS_ISTS, 16'h0000, "ists");
    p1(1'b0);
    p1(1'b1);
    rc(OFS_ISTS, 16'h0002, "ists");
    p1(1'b0);
    wr(OFS_CCTRL, 16'h0000);
    wr(OFS_CM1, 16'h0031);
    wr(OFS_CCTRL, 16'h0001);
    wr(OFS_ISTS, 16'h0000);
    ch1_pin <= 1'b1;
    go(4);
    p1(1'b0);
    rc(OFS_ISTS, 16'h0000, "ists");
    p1(1'b1);
    go(8);
    rc(OFS_ISTS, 16'h0002, "ists");
    wr(OFS_CCTRL, 16'h0000);
    wr(OFS_CM1, 16'h0002);
    wr(OFS_CCTRL, 16'h0001);
    wr(OFS_ISTS, 16'h0000);
    ch2_pin <= 1'b1;
    go(6);
    rc(OFS_ISTS, 16'h0002, "ists");
    wr(OFS_CM1, 16'h0001);
    rc(OFS_CM1, 16'h0002, "cm1");
    wr(OFS_CCTRL, 16'h0000);
    wr(OFS_CM1, 16'h0300);
    wr(OFS_CCTRL, 16'h0010);
    wr(OFS_ISTS, 16'h0000);
    internal_trigger_channel_in <= 1'b1;
    go(4);
    rc(OFS_ISTS, 16'h0000, "ists");
    internal_trigger_channel_in <= 1'b0;
    trigger_input_select <= 1'b1;
    go(2);
    internal_trigger_channel_in <= 1'b1;
    go(4);
    rc(OFS_ISTS, 16'h0004, "ists");
    $display("test capture done");
    give_verdict();
  end
endmodule : tb_timer_channel_event_control
